// ==== aps_path_select.v ====
// Analog front end path select decoder with classic Wishbone register slave
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "aps_defs.vh"

// What this block does
// - Filtered input code 0..14 closes one of fifteen positive sources; 15 none.
// - Negative input code 0..7 closes one of eight sources; 0 is signal ground.
// - High reference code picks divider ref, divider, millivolt or aux input three.
// - Low reference codes 0 and 6 pick ground; 1..5 five other sources.
// - Comparator positive code closes one of sixteen sources.
// - Outside capacitor and short modes, comparator negative follows its two-bit select.
// - Short testing without capacitor mode forces short threshold on comparator negative.
// - Capacitor mode, low range: charge toggle picks charge or discharge threshold one.
// - Capacitor mode, high range: charge toggle picks charge or discharge threshold two.
// - Paths go through the prefilter unless their bypass bits are set.
// - Buffer enable low switches the buffer off and floats its output.
// - Gain bit low gives unity gain, high gives external network gain.
// - Bypass bit high sends the AC signal out on the bypass pin.
// - Diode bit low uses the internal diode, high the external one.
// - Rectifier enable low powers down the rectifier amplifier.
// - Comparator enable bit switches the main comparator on or off.
// - Hysteresis bit switches comparator hysteresis off or on.
// - Comparator result feeds counter and charge toggle, inverted pin, and status.
// - Function code 0011 asserts direct output and closes the direct divider switch.
// - Function codes 101x mean capacitor mode, 100x mean short testing.
module aps_path_select (
  input  wire        clk_i,                   // Clock, 100 MHz
  input  wire        rst_i,                   // Synchronous reset, active high
  input  wire        wb_cyc_i,                // Wishbone cycle
  input  wire        wb_stb_i,                // Wishbone strobe
  input  wire        wb_we_i,                 // Wishbone write enable
  input  wire [3:0]  wb_adr_i,                // Wishbone byte address
  input  wire [3:0]  wb_sel_i,                // Wishbone byte lanes
  input  wire [31:0] wb_dat_i,                // Wishbone write data
  output reg  [31:0] wb_dat_o,                // Wishbone read data
  output reg         wb_ack_o,                // Wishbone acknowledge
  input  wire        cmp_result_i,            // Main comparator raw output
  output reg  [14:0] pos_input_mux_o,         // Filtered positive path switches
  output reg  [7:0]  neg_input_mux_o,         // Negative path switches
  output reg  [3:0]  ref_high_mux_o,          // High reference switches
  output reg  [5:0]  ref_low_mux_o,           // Low reference switches
  output reg  [15:0] cmp_source_mux_o,        // Comparator positive switches
  output reg  [7:0]  cmp_neg_input_o,         // Comparator negative switches
  output reg         prefilter_pos_o,         // Positive path via prefilter
  output reg         prefilter_neg_o,         // Negative path via prefilter
  output reg         prefilter_bypass_pos_o,  // Positive path straight to converter
  output reg         prefilter_bypass_neg_o,  // Negative path straight to converter
  output reg         ac_buf_on_o,             // AC buffer powered
  output reg         ac_buf_hiz_o,            // AC buffer output floating
  output reg         ac_gain_ext_o,           // External gain network selected
  output reg         ac_buf_path_o,           // AC out through buffer
  output reg         ac_bypass_pin_o,         // AC out on bypass pin
  output reg         int_diode_o,             // Internal rectifier diode in use
  output reg         ext_diode_sel_o,         // External rectifier diode in use
  output reg         rectifier_on_o,          // Rectifier amplifier powered
  output reg         cmp_on_o,                // Main comparator powered
  output reg         hysteresis_on_o,         // Comparator hysteresis active
  output reg         freq_count_in_o,         // Comparator result to counter
  output reg         charge_toggle_o,         // Charge or discharge select
  output reg         cmp_inv_o,               // Inverted comparator result pin
  output reg         direct_out_en_o,         // Direct high bandwidth control
  output reg         direct_volt_out_o        // Divider to direct output switch
);
  reg  [31:0] sel_reg;
  reg  [`APS_CTRL_W-1:0] ctrl_reg;
  reg  [31:0] next_rdata;
  reg  [31:0] next_sel;
  reg  [7:0]  next_cmp_neg;
  reg  [5:0]  next_ref_low;
  wire        cmp_sync;
  wire        req;
  wire        cap_meas;
  wire        short_test;
  wire        direct_mode;
  wire [3:0]  filt_in_sel;
  wire [2:0]  neg_in_sel;
  wire [1:0]  ref_hi_sel;
  wire [2:0]  ref_lo_sel;
  wire [3:0]  cmp_pos_sel;
  wire [1:0]  cmp_neg_sel;
  wire [3:0]  meas_function;
  wire [14:0] pos_hot;
  wire [7:0]  neg_hot;
  wire [3:0]  rhi_hot;
  wire [6:0]  rlo_hot;
  wire [15:0] cmp_hot;
  wire [31:0] lane_mask;

  assign filt_in_sel   = sel_reg[`APS_FILT_IN_LSB +: 4];
  assign neg_in_sel    = sel_reg[`APS_NEG_IN_LSB +: 3];
  assign ref_hi_sel    = sel_reg[`APS_REF_HI_LSB +: 2];
  assign ref_lo_sel    = sel_reg[`APS_REF_LO_LSB +: 3];
  assign cmp_pos_sel   = sel_reg[`APS_CMP_POS_LSB +: 4];
  assign cmp_neg_sel   = sel_reg[`APS_CMP_NEG_LSB +: 2];
  assign meas_function = sel_reg[`APS_FUNC_LSB +: 4];

  // Mode decode from the function code
  assign cap_meas    = (meas_function[3:1] == `APS_FUNC_CAP_HI);
  assign short_test  = (meas_function[3:1] == `APS_FUNC_SHORT_HI);
  assign direct_mode = (meas_function == `APS_FUNC_DIRECT);

  aps_sync2 u_cmp_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cmp_result_i),
    .q_o   (cmp_sync)
  );

  // Select decoders; out-of-range codes close nothing
  aps_onehot_dec #(.SEL_W(4), .SRC_N(`APS_POS_SRC_N)) u_pos_dec (
    .sel_i (filt_in_sel),
    .hot_o (pos_hot)
  );

  aps_onehot_dec #(.SEL_W(3), .SRC_N(`APS_NEG_SRC_N)) u_neg_dec (
    .sel_i (neg_in_sel),
    .hot_o (neg_hot)
  );

  aps_onehot_dec #(.SEL_W(2), .SRC_N(`APS_RHI_SRC_N)) u_rhi_dec (
    .sel_i (ref_hi_sel),
    .hot_o (rhi_hot)
  );

  aps_onehot_dec #(.SEL_W(3), .SRC_N(`APS_RLO_CODE_N)) u_rlo_dec (
    .sel_i (ref_lo_sel),
    .hot_o (rlo_hot)
  );

  aps_onehot_dec #(.SEL_W(4), .SRC_N(`APS_CMP_SRC_N)) u_cmp_dec (
    .sel_i (cmp_pos_sel),
    .hot_o (cmp_hot)
  );

  // Two codes share the ground switch, code 7 closes nothing
  always @* begin
    next_ref_low    = rlo_hot[5:0];
    next_ref_low[0] = rlo_hot[0] | rlo_hot[6];
  end

  // Comparator negative input selection
  always @* begin
    next_cmp_neg = 8'h00;
    if (cap_meas) begin
      if (ctrl_reg[`APS_CAP_HI_BIT]) begin
        if (cmp_sync)
          next_cmp_neg[`APS_CN_DIS2] = 1'b1;
        else
          next_cmp_neg[`APS_CN_CHG2] = 1'b1;
      end else begin
        if (cmp_sync)
          next_cmp_neg[`APS_CN_DIS1] = 1'b1;
        else
          next_cmp_neg[`APS_CN_CHG1] = 1'b1;
      end
    end else if (short_test) begin
      next_cmp_neg[`APS_CN_SHORT] = 1'b1;
    end else begin
      case (cmp_neg_sel)
        2'h0: next_cmp_neg[`APS_CN_GND]    = 1'b1;
        2'h1: next_cmp_neg[`APS_CN_SPARE]  = 1'b1;
        2'h2: next_cmp_neg[`APS_CN_CHG2]   = 1'b1;
        2'h3: next_cmp_neg[`APS_CN_OHMREF] = 1'b1;
        default: next_cmp_neg = 8'h00;
      endcase
    end
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always @* begin
    next_sel = (sel_reg & ~lane_mask) | (wb_dat_i & lane_mask & `APS_SEL_MASK);
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `APS_OFS_SEL:    next_rdata = sel_reg;
      `APS_OFS_CTRL:   next_rdata[`APS_CTRL_W-1:0] = ctrl_reg;
      `APS_OFS_STATUS: begin
        next_rdata[`APS_ST_CMP_BIT]    = cmp_sync;
        next_rdata[`APS_ST_CAP_BIT]    = cap_meas;
        next_rdata[`APS_ST_SHORT_BIT]  = short_test;
        next_rdata[`APS_ST_DIRECT_BIT] = direct_mode;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      sel_reg  <= `APS_SEL_RESET;
      ctrl_reg <= `APS_CTRL_RESET;
    end else begin
      wb_ack_o <= req;
      if (req)
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : next_rdata;
      if (req && wb_we_i && wb_adr_i == `APS_OFS_SEL)
        sel_reg <= next_sel;
      if (req && wb_we_i && wb_adr_i == `APS_OFS_CTRL) begin
        if (wb_sel_i[0])
          ctrl_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          ctrl_reg[`APS_CTRL_W-1:8] <= wb_dat_i[`APS_CTRL_W-1:8];
      end
    end
  end

  // Registered switch and control outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      pos_input_mux_o        <= 15'h0000;
      neg_input_mux_o        <= 8'h00;
      ref_high_mux_o         <= 4'h0;
      ref_low_mux_o          <= 6'h00;
      cmp_source_mux_o       <= 16'h0000;
      cmp_neg_input_o        <= 8'h00;
      prefilter_pos_o        <= 1'b0;
      prefilter_neg_o        <= 1'b0;
      prefilter_bypass_pos_o <= 1'b0;
      prefilter_bypass_neg_o <= 1'b0;
      ac_buf_on_o            <= 1'b0;
      ac_buf_hiz_o           <= 1'b1;
      ac_gain_ext_o          <= 1'b0;
      ac_buf_path_o          <= 1'b0;
      ac_bypass_pin_o        <= 1'b0;
      int_diode_o            <= 1'b0;
      ext_diode_sel_o        <= 1'b0;
      rectifier_on_o         <= 1'b0;
      cmp_on_o               <= 1'b0;
      hysteresis_on_o        <= 1'b0;
      freq_count_in_o        <= 1'b0;
      charge_toggle_o        <= 1'b0;
      cmp_inv_o              <= 1'b1;
      direct_out_en_o        <= 1'b0;
      direct_volt_out_o      <= 1'b0;
    end else begin
      pos_input_mux_o        <= pos_hot;
      neg_input_mux_o        <= neg_hot;
      ref_high_mux_o         <= rhi_hot;
      ref_low_mux_o          <= next_ref_low;
      cmp_source_mux_o       <= cmp_hot;
      cmp_neg_input_o        <= next_cmp_neg;
      prefilter_pos_o        <= ~ctrl_reg[`APS_BYP_POS_BIT];
      prefilter_neg_o        <= ~ctrl_reg[`APS_BYP_NEG_BIT];
      prefilter_bypass_pos_o <= ctrl_reg[`APS_BYP_POS_BIT];
      prefilter_bypass_neg_o <= ctrl_reg[`APS_BYP_NEG_BIT];
      ac_buf_on_o            <= ctrl_reg[`APS_AC_ON_BIT];
      ac_buf_hiz_o           <= ~ctrl_reg[`APS_AC_ON_BIT];
      ac_gain_ext_o          <= ctrl_reg[`APS_AC_GAIN_BIT];
      ac_buf_path_o          <= ~ctrl_reg[`APS_AC_BYP_BIT];
      ac_bypass_pin_o        <= ctrl_reg[`APS_AC_BYP_BIT];
      int_diode_o            <= ~ctrl_reg[`APS_EXT_DIODE_BIT];
      ext_diode_sel_o        <= ctrl_reg[`APS_EXT_DIODE_BIT];
      rectifier_on_o         <= ctrl_reg[`APS_RECT_ON_BIT];
      cmp_on_o               <= ctrl_reg[`APS_CMP_ON_BIT];
      hysteresis_on_o        <= ctrl_reg[`APS_HYST_BIT];
      freq_count_in_o        <= cmp_sync;
      charge_toggle_o        <= cmp_sync;
      cmp_inv_o              <= ~cmp_sync;
      direct_out_en_o        <= direct_mode;
      direct_volt_out_o      <= direct_mode;
    end
  end
endmodule

// ==== aps_defs.vh ====
// Register map, field positions and reset values of the path select decoder
`ifndef APS_DEFS_VH
`define APS_DEFS_VH

`define APS_ADDR_W        4
`define APS_OFS_SEL       4'h0
`define APS_OFS_CTRL      4'h4
`define APS_OFS_STATUS    4'h8

// Select register fields
`define APS_FILT_IN_LSB   0
`define APS_NEG_IN_LSB    4
`define APS_REF_HI_LSB    8
`define APS_REF_LO_LSB    12
`define APS_CMP_POS_LSB   16
`define APS_CMP_NEG_LSB   20
`define APS_FUNC_LSB      24
`define APS_SEL_MASK      32'h0f3f_737f
`define APS_SEL_RESET     32'h0000_0000

// Control register bits
`define APS_BYP_POS_BIT   0
`define APS_BYP_NEG_BIT   1
`define APS_AC_ON_BIT     2
`define APS_AC_GAIN_BIT   3
`define APS_AC_BYP_BIT    4
`define APS_EXT_DIODE_BIT 5
`define APS_RECT_ON_BIT   6
`define APS_CMP_ON_BIT    7
`define APS_HYST_BIT      8
`define APS_CAP_HI_BIT    9
`define APS_CTRL_W        10
`define APS_CTRL_RESET    10'h000

// Status register bits
`define APS_ST_CMP_BIT    0
`define APS_ST_CAP_BIT    1
`define APS_ST_SHORT_BIT  2
`define APS_ST_DIRECT_BIT 3

// Measurement function codes
`define APS_FUNC_DIRECT   4'h3
`define APS_FUNC_SHORT_HI 3'h4
`define APS_FUNC_CAP_HI   3'h5

// Select code counts
`define APS_POS_SRC_N     15
`define APS_NEG_SRC_N     8
`define APS_RHI_SRC_N     4
`define APS_RLO_CODE_N    7
`define APS_RLO_SRC_N     6
`define APS_CMP_SRC_N     16
`define APS_CNEG_SRC_N    8

// Comparator negative input one-hot positions
`define APS_CN_GND        0
`define APS_CN_SPARE      1
`define APS_CN_CHG2       2
`define APS_CN_OHMREF     3
`define APS_CN_SHORT      4
`define APS_CN_CHG1       5
`define APS_CN_DIS1       6
`define APS_CN_DIS2       7

`endif

// ==== aps_onehot_dec.v ====
// Select code to one-hot switch decoder, codes past the source count close nothing
`timescale 1ns/10ps
module aps_onehot_dec #(
  parameter SEL_W = 4,
  parameter SRC_N = 15
) (
  input  wire [SEL_W-1:0] sel_i,  // Select code
  output wire [SRC_N-1:0] hot_o   // One switch per source
);
  genvar g;
  generate
    for (g = 0; g < SRC_N; g = g + 1) begin : g_src
      localparam [SEL_W-1:0] CODE = g;
      assign hot_o[g] = (sel_i == CODE);
    end
  endgenerate
endmodule

// ==== aps_sync2.v ====
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/10ps
module aps_sync2 (
  input  wire clk_i,  // Clock
  input  wire rst_i,  // Synchronous reset, active high
  input  wire d_i,    // Asynchronous level
  output reg  q_o     // Synchronised level
);
  reg meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ==== aps_cmp_model.sv ====
// Comparator stand-in at the analog side of the path select decoder
`timescale 1ns/10ps
module aps_cmp_model (
  input  wire clk_i,     // Clock, only to place output changes
  input  wire cmp_on_i,  // Comparator power from the decoder
  input  wire level_i,   // Positive input above negative input
  output reg  cmp_o      // Raw comparator output
);
  initial cmp_o = 1'b0;
  // Unpowered comparator sits low; output moves away from the rising edge
  always @(negedge clk_i) begin
    cmp_o <= cmp_on_i & level_i;
  end
endmodule

// ==== aps_path_select_assertions.sv ====
// Bus timing and decode checks for the path select decoder
`timescale 1ns/10ps
`include "aps_defs.vh"
module aps_path_select_assertions (
  input wire        clk_i,            // Clock
  input wire        rst_i,            // Reset
  input wire        wb_cyc_i,         // Cycle
  input wire        wb_stb_i,         // Strobe
  input wire        wb_we_i,          // Write enable
  input wire [3:0]  wb_adr_i,         // Address
  input wire [3:0]  wb_sel_i,         // Byte lanes
  input wire [31:0] wb_dat_i,         // Write data
  input wire        wb_ack_o,         // Acknowledge
  input wire        cmp_result_i,     // Raw comparator
  input wire [14:0] pos_input_mux_o,  // Positive switches
  input wire [7:0]  neg_input_mux_o,  // Negative switches
  input wire [5:0]  ref_low_mux_o,    // Low reference switches
  input wire        ac_buf_on_o,      // Buffer powered
  input wire        ac_buf_hiz_o,     // Buffer floating
  input wire        ac_gain_ext_o,    // External gain
  input wire        ac_bypass_pin_o,  // Bypass pin
  input wire        freq_count_in_o,  // Counter input
  input wire        cmp_inv_o,        // Inverted result
  input wire        direct_out_en_o   // Direct output control
);
  reg  [31:0] wd;
  wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (wb_sel_i == 4'hf);
  wire        ws = wr & (wb_adr_i == `APS_OFS_SEL);
  wire        wc = wr & (wb_adr_i == `APS_OFS_CTRL);
  // Last full-word write data
  always @(posedge clk_i) begin
    if (wr)
      wd <= wb_dat_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_POS: assert property (ws |-> ##2 pos_input_mux_o ==
    ((wd[3:0] == 4'hf) ? 15'h0 : (15'h1 << wd[3:0]))) else $error("positive mux");
  AST_NEG: assert property (ws |-> ##2 neg_input_mux_o == (8'h1 << wd[6:4]))
    else $error("negative mux");
  AST_RLO: assert property (ws |-> ##2 ref_low_mux_o == ((wd[14:12] == 3'h7) ? 6'h0 :
    (wd[14:12] == 3'h6) ? 6'h1 : (6'h1 << wd[14:12]))) else $error("low reference mux");
  AST_AC: assert property (wc |-> ##2 {ac_buf_on_o, ac_buf_hiz_o, ac_gain_ext_o,
    ac_bypass_pin_o} == {wd[2], !wd[2], wd[3], wd[4]}) else $error("buffer controls");
  AST_CMP: assert property (freq_count_in_o == $past(cmp_result_i, 3) &&
    cmp_inv_o == !freq_count_in_o) else $error("comparator result path");
  AST_DIR: assert property (ws |-> ##2 direct_out_en_o == (wd[27:24] == 4'h3))
    else $error("direct output");
  cover property (ws ##2 direct_out_en_o);
  cover property (wc ##2 ac_bypass_pin_o);
  cover property ($rose(freq_count_in_o));
endmodule
bind aps_path_select aps_path_select_assertions u_aps_path_select_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .cmp_result_i(cmp_result_i), .pos_input_mux_o(pos_input_mux_o),
  .neg_input_mux_o(neg_input_mux_o), .ref_low_mux_o(ref_low_mux_o),
  .ac_buf_on_o(ac_buf_on_o), .ac_buf_hiz_o(ac_buf_hiz_o), .ac_gain_ext_o(ac_gain_ext_o),
  .ac_bypass_pin_o(ac_bypass_pin_o), .freq_count_in_o(freq_count_in_o),
  .cmp_inv_o(cmp_inv_o), .direct_out_en_o(direct_out_en_o));

// ==== aps_path_select_tb.sv ====
// Register-driven test of the path select decoder
`timescale 1ns/10ps
`include "aps_defs.vh"
module aps_path_select_tb;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg  [3:0]  sel = 4'hf;
  reg  [31:0] wdat = 32'h0;
  reg         level = 1'b0;
  reg  [31:0] q, d;
  wire        cmp_res, ack, fci, ctg, cinv, den, direct_volt_out;
  wire [31:0] rdat;
  wire [14:0] pos;
  wire [7:0]  neg, cng;
  wire [3:0]  rhi;
  wire [5:0]  rlo;
  wire [15:0] cps;
  wire [13:0] ctl;
  integer     err_count = 0;
  integer     tests_run = 0;
  integer     cycles = 0;
  integer     i, j;
  aps_path_select u_aps_path_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_result_i(cmp_res), .pos_input_mux_o(pos),
    .neg_input_mux_o(neg), .ref_high_mux_o(rhi), .ref_low_mux_o(rlo),
    .cmp_source_mux_o(cps), .cmp_neg_input_o(cng), .prefilter_pos_o(ctl[13]),
    .prefilter_neg_o(ctl[12]), .prefilter_bypass_pos_o(ctl[11]),
    .prefilter_bypass_neg_o(ctl[10]), .ac_buf_on_o(ctl[9]), .ac_buf_hiz_o(ctl[8]),
    .ac_gain_ext_o(ctl[7]), .ac_buf_path_o(ctl[6]), .ac_bypass_pin_o(ctl[5]),
    .int_diode_o(ctl[4]), .ext_diode_sel_o(ctl[3]), .rectifier_on_o(ctl[2]),
    .cmp_on_o(ctl[1]), .hysteresis_on_o(ctl[0]), .freq_count_in_o(fci),
    .charge_toggle_o(ctg), .cmp_inv_o(cinv), .direct_out_en_o(den), .direct_volt_out_o(direct_volt_out));
  aps_cmp_model u_aps_cmp_model (.clk_i(clk_i), .cmp_on_i(ctl[1]), .level_i(level),
    .cmp_o(cmp_res));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task final_report;
    begin
      if (err_count == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        err_count = err_count + 1;
      end
    end
  endtask
  // One classic cycle; returns with outputs settled and read data in q
  task wb(input [3:0] a, input w, input [31:0] dd);
    integer n;
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dd;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (ack !== 1'b1) begin
        err_count = err_count + 1;
        final_report;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(negedge clk_i);
    end
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({ctl, cinv}, 32'h201);
    wb(`APS_OFS_SEL, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(`APS_OFS_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0);
    for (i = 0; i < 16; i = i + 1) begin
      d = {8'h0, 2'h0, i[1:0], i[3:0], 1'b0, i[2:0], 2'h0, i[1:0], 1'b0, i[2:0], i[3:0]};
      wb(`APS_OFS_SEL, 1'b1, d | 32'hf0c0_8c80);
      chk(pos, (i == 15) ? 32'h0 : (32'h1 << i));
      chk(neg, 32'h1 << i[2:0]);
      chk(rhi, 32'h1 << i[1:0]);
      chk(rlo, (i[2:0] == 7) ? 32'h0 : (i[2:0] == 6) ? 32'h1 : (32'h1 << i[2:0]));
      chk(cps, 32'h1 << i);
      chk(cng, 32'h1 << i[1:0]);
      wb(`APS_OFS_SEL, 1'b0, 32'h0);
      chk(q, d);
    end
    for (i = 0; i < 16; i = i + 1) begin
      wb(`APS_OFS_SEL, 1'b1, {4'h0, i[3:0], 2'h0, 2'h1, 20'h0});
      chk(cng, (i[3:1] == 5) ? 32'h20 : (i[3:1] == 4) ? 32'h10 : 32'h2);
      chk({den, direct_volt_out}, (i == 3) ? 32'h3 : 32'h0);
      wb(`APS_OFS_STATUS, 1'b0, 32'h0);
      chk(q, {i == 3, i[3:1] == 4, i[3:1] == 5, 1'b0});
    end
    wb(`APS_OFS_SEL, 1'b1, 32'h0b00_0000);
    for (j = 0; j < 4; j = j + 1) begin
      wb(`APS_OFS_CTRL, 1'b1, {22'h0, j[1], 1'b0, 1'b1, 7'h0});
      @(posedge clk_i);
      level <= j[0];
      repeat (6) @(negedge clk_i);
      chk(cng, 32'h1 << ((j == 0) ? 5 : (j == 1) ? 6 : (j == 2) ? 2 : 7));
      chk({fci, ctg, cinv}, j[0] ? 32'h6 : 32'h1);
      wb(`APS_OFS_STATUS, 1'b0, 32'h0);
      chk(q, 32'h2 | j[0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'h3ff : (i == 2) ? 32'h155 : 32'h2aa;
      wb(`APS_OFS_CTRL, 1'b1, d | 32'hffff_fc00);
      chk(ctl, {!d[0], !d[1], d[0], d[1], d[2], !d[2], d[3], !d[4], d[4],
                !d[5], d[5], d[6], d[7], d[8]});
      wb(`APS_OFS_CTRL, 1'b0, 32'h0);
      chk(q, d);
    end
    // Read-only status and an unmapped place must ignore writes
    wb(`APS_OFS_STATUS, 1'b1, 32'hffff_ffff);
    wb(4'hc, 1'b1, 32'hffff_ffff);
    wb(4'hc, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(`APS_OFS_STATUS, 1'b0, 32'h0);
    chk(q, 32'h3);
    // Lane zero only: just the low byte of the select word changes
    @(posedge clk_i);
    sel <= 4'h1;
    wb(`APS_OFS_SEL, 1'b1, 32'hffff_ffff);
    wb(`APS_OFS_SEL, 1'b0, 32'h0);
    chk(q, 32'h0b00_007f);
    chk(pos, 32'h0);
    final_report;
  end
endmodule
